// *** bir_pkg.sv ***
// package for the board interrupt routing block: port input map,
// polarity masks and the carrier structs shared by both design files.
// assumes a single 50 MHz core clock and synchronous active-high reset.
package bir_pkg;

	localparam int unsigned BIR_PORT_W = 32;
	localparam int unsigned BIR_SRC_W = 16;

	// port input bit positions
	localparam int unsigned BIR_GP_SERIAL = 0;
	localparam int unsigned BIR_GP_ABORT = 2;
	localparam int unsigned BIR_GP_CLOCK_THERM = 3;
	localparam int unsigned BIR_GP_IO_MODULE = 5;
	localparam int unsigned BIR_GP_WATCHDOG = 6;
	localparam int unsigned BIR_GP_PHY = 7;
	localparam int unsigned BIR_GP_SLOT_BASE = 16;
	localparam int unsigned BIR_GP_BRIDGE_BASE = 20;
	localparam int unsigned BIR_GP_GROUP_N = 4;

	// inputs that take part as level interrupt sources
	localparam logic [31:0] BIR_SRC_MASK = 32'h00ff_00ed;
	// sources whose active level is high; all other sources are active low
	localparam logic [31:0] BIR_HIGH_MASK = 32'h0000_0021;
	// unused inputs, pulled high on the board
	localparam logic [31:0] BIR_UNUSED_MASK = 32'hc000_0012;
	// reserved inputs, never sources
	localparam logic [31:0] BIR_RESERVED_MASK = 32'h0f00_0000;

	// routing destinations; both share the pending set
	localparam int unsigned BIR_DEST_N = 2;

	localparam logic [31:0] BIR_PEND_RST = 32'h0000_0000;

	// named view of the fourteen live sources and two spare bits
	typedef struct packed
	{
		logic [3:0] bridge_local_irq;
		logic [3:0] slot_irq;
		logic phy_irq;
		logic watchdog_nonmaskable;
		logic io_module;
		logic clock_therm;
		logic abort_switch;
		logic serial_port;
		logic [1:0] spare;
	} bir_src_t;

	typedef struct packed
	{
		logic cpu_irq;
		logic pci_irq;
	} bir_route_t;

	// true level of a port input, after its polarity is applied
	function automatic logic [31:0] bir_active(input logic [31:0] pins);
		bir_active = (pins ~^ BIR_HIGH_MASK) & BIR_SRC_MASK;
	endfunction

endpackage

// *** bir_sync.sv ***
// two-stage synchroniser bank for the general-purpose port inputs.
// assumes the pins are asynchronous to core_clk_i.
`timescale 1ns/1ps
module bir_sync
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [bir_pkg::BIR_PORT_W-1:0] pin_i,
	output logic [bir_pkg::BIR_PORT_W-1:0] sync_o
);
	import bir_pkg::*;

	logic [BIR_PORT_W-1:0] meta_ff;
	logic [BIR_PORT_W-1:0] sync_ff;

	////////////////////////////////////////////////////////////////////////
	// reset to each pin's idle level, so no false request follows reset
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			meta_ff <= ~BIR_HIGH_MASK;
			sync_ff <= ~BIR_HIGH_MASK;
		end
		else
		begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule

// *** bir_top.sv ***
// board interrupt routing: samples the general-purpose port inputs,
// applies each source's level polarity and routes to cpu and pci.
// assumes asynchronous pins, one 50 MHz clock, sync active-high reset.
// limitation: a level shorter than one clock may never be seen.
// no source latches, so software never clears anything here;
// the enables gate the routes only, pending shows raw levels.
// the watchdog request bypasses both enables on purpose.
// every output is a flop, so each lags its pin by three edges.
//
// What this block does
// - route requests toward cpu and pci
// - pending state readable at cpu side
// - external sources only via port inputs
// - input 0 active high, serial ports
// - inputs 1,4,30,31 unused, pulled high
// - inputs 2,6,7 active low
// - input 5 active high io module
// - inputs 16-19 active low slot lines
// - inputs 20-23 active low bridge lines
// - inputs 24-27 reserved, never sources
`timescale 1ns/1ps
module bir_top
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [bir_pkg::BIR_PORT_W-1:0] general_port_input_i,
	input wire logic cpu_int_en_i,
	input wire logic pci_int_en_i,
	output logic [bir_pkg::BIR_PORT_W-1:0] pending_o,
	output bir_pkg::bir_src_t src_o,
	output bir_pkg::bir_route_t route_o,
	output logic nonmaskable_o
);
	import bir_pkg::*;

	logic [BIR_PORT_W-1:0] pin_sync;
	logic [BIR_PORT_W-1:0] pend_ff;
	logic [BIR_PORT_W-1:0] nxt_pend;
	bir_src_t src_ff;
	bir_src_t nxt_src;
	bir_route_t route_ff;
	bir_route_t nxt_route;
	logic nmi_ff;
	logic any_pend;
	logic nxt_nmi;

	////////////////////////////////////////////////////////////////////////
	// pins sampled into core clock
	// two flops per pin; only the second is read by logic
	bir_sync u_sync
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.pin_i(general_port_input_i),
		.sync_o(pin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// polarity and source selection
	// each source outside the slot and bridge groups of four is decoded on its own so a board change to one line
	// touches one statement; nothing else may reach the pending set
	function automatic logic bir_high_level
	(
		input logic [BIR_PORT_W-1:0] pins,
		input int unsigned pos
	);
		bir_high_level = pins[pos];
	endfunction

	function automatic logic bir_low_level
	(
		input logic [BIR_PORT_W-1:0] pins,
		input int unsigned pos
	);
		bir_low_level = ~pins[pos];
	endfunction

	function automatic logic [BIR_GP_GROUP_N-1:0] bir_low_group
	(
		input logic [BIR_PORT_W-1:0] pins,
		input int unsigned base
	);
		bir_low_group = ~pins[base +: BIR_GP_GROUP_N];
	endfunction

	always_comb
	begin
		nxt_pend = BIR_PEND_RST;
		nxt_pend[BIR_GP_SERIAL] =
			bir_high_level(pin_sync, BIR_GP_SERIAL);
		// abort, watchdog and phy lines, active low
		nxt_pend[BIR_GP_ABORT] =
			bir_low_level(pin_sync, BIR_GP_ABORT);
		nxt_pend[BIR_GP_WATCHDOG] =
			bir_low_level(pin_sync, BIR_GP_WATCHDOG);
		nxt_pend[BIR_GP_PHY] =
			bir_low_level(pin_sync, BIR_GP_PHY);
		// clock and thermostat share one low line
		nxt_pend[BIR_GP_CLOCK_THERM] =
			bir_low_level(pin_sync, BIR_GP_CLOCK_THERM);
		nxt_pend[BIR_GP_IO_MODULE] =
			bir_high_level(pin_sync, BIR_GP_IO_MODULE);
		// slot lines, each shared with the rotated slot
		nxt_pend[BIR_GP_SLOT_BASE +: BIR_GP_GROUP_N] =
			bir_low_group(pin_sync, BIR_GP_SLOT_BASE);
		// bridge local lines, shared with the carrier
		nxt_pend[BIR_GP_BRIDGE_BASE +: BIR_GP_GROUP_N] =
			bir_low_group(pin_sync, BIR_GP_BRIDGE_BASE);
		nxt_pend = nxt_pend & ~(BIR_UNUSED_MASK | BIR_RESERVED_MASK);
		// the polarity table bounds what may show
		nxt_pend = nxt_pend & bir_active(pin_sync);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pend_ff <= BIR_PEND_RST;
		end
		else
		begin
			pend_ff <= nxt_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// named view; bridge lines pass through as its own map sets them
	always_comb
	begin
		nxt_src = '0;
		nxt_src.serial_port = nxt_pend[BIR_GP_SERIAL];
		nxt_src.abort_switch = nxt_pend[BIR_GP_ABORT];
		nxt_src.clock_therm = nxt_pend[BIR_GP_CLOCK_THERM];
		nxt_src.io_module = nxt_pend[BIR_GP_IO_MODULE];
		nxt_src.watchdog_nonmaskable = nxt_pend[BIR_GP_WATCHDOG];
		nxt_src.phy_irq = nxt_pend[BIR_GP_PHY];
		nxt_src.slot_irq = nxt_pend[BIR_GP_SLOT_BASE +: BIR_GP_GROUP_N];
		// bridge lines, mapping is bridge side
		nxt_src.bridge_local_irq =
			nxt_pend[BIR_GP_BRIDGE_BASE +: BIR_GP_GROUP_N];
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			src_ff <= '0;
		end
		else
		begin
			src_ff <= nxt_src;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one wide or, shared by both routes
	always_comb
	begin
		any_pend = |nxt_pend;
	end

	// routing to both destinations
	always_comb
	begin
		// any pending source reaches each enabled target
		// cpu target
		nxt_route.cpu_irq = cpu_int_en_i & any_pend;
		// pci target
		nxt_route.pci_irq = pci_int_en_i & any_pend;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			route_ff <= '0;
		end
		else
		begin
			route_ff <= nxt_route;
		end
	end

	// watchdog decoded from its own pin, not via pending
	always_comb
	begin
		nxt_nmi = bir_low_level(pin_sync, BIR_GP_WATCHDOG);
	end

	// watchdog request is not gated by enables: it must always be seen
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			nmi_ff <= 1'b0;
		end
		else
		begin
			nmi_ff <= nxt_nmi;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: every one comes straight from its own flop
	assign pending_o = pend_ff;
	assign src_o = src_ff;
	assign route_o = route_ff;
	assign nonmaskable_o = nmi_ff;
endmodule

// *** bir_top_props.sv ***
// checker for the board interrupt routing ports.
// assumes a bind onto bir_top.
`timescale 1ns/1ps
module bir_top_props
import bir_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [31:0] general_port_input_i,
	input wire logic cpu_int_en_i,
	input wire logic pci_int_en_i,
	input wire logic [31:0] pending_o,
	input wire bir_pkg::bir_src_t src_o,
	input wire bir_pkg::bir_route_t route_o,
	input wire logic nonmaskable_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	logic [2:0] age_ff;
	logic ok;
	// sync stages hold idle levels just after reset, so wait them out
	always_ff @(posedge core_clk_i)
		age_ff <= srst_i ? 3'h0 : age_ff + {2'h0, !ok};
	assign ok = age_ff == 3'h7;
	a_pend_level:
		assert property (ok |-> pending_o == (BIR_SRC_MASK &
			($past(general_port_input_i, 3) ~^ BIR_HIGH_MASK)))
		else $error("pending wrong");
	a_unused_quiet:
		assert property ((pending_o & BIR_UNUSED_MASK) == 32'h0)
		else $error("unused shown");
	a_reserved_quiet:
		assert property ((pending_o & BIR_RESERVED_MASK) == 32'h0)
		else $error("reserved shown");
	a_serial_high:
		assert property (ok |-> pending_o[0] ==
			$past(general_port_input_i[0], 3))
		else $error("serial wrong");
	a_nmi_low:
		assert property (ok |-> nonmaskable_o ==
			!$past(general_port_input_i[6], 3))
		else $error("nmi wrong");
	a_cpu_route:
		assert property (route_o.cpu_irq ==
			(|pending_o && $past(cpu_int_en_i)))
		else $error("cpu route wrong");
	a_pci_route:
		assert property (route_o.pci_irq ==
			(|pending_o && $past(pci_int_en_i)))
		else $error("pci route wrong");
	a_src_view:
		assert property (src_o == {pending_o[23:16], pending_o[7:5],
			pending_o[3:2], pending_o[0], 2'h0})
		else $error("src view wrong");
endmodule
bind bir_top bir_top_props u_bir_top_props (.*);

// *** bir_periph.sv ***
// board peripherals driving the port inputs.
// assumes req_i bit n high means source n wants service.
`timescale 1ns/1ps
module bir_periph
(
	input wire logic [31:0] req_i,
	input wire logic temp_hi_i,
	input wire logic [3:0] bridge_src_i,
	input wire logic [7:0] bridge_map_i,
	output logic [31:0] pins_o
);
	logic [3:0] local_line;
	logic [31:0] want;
	// bridge steers each source to the line its map picks
	always_comb
	begin
		local_line = 4'h0;
		for (int s = 0; s < 4; s++)
			if (bridge_src_i[s])
				local_line[bridge_map_i[2*s +: 2]] = 1'b1;
	end
	// thermostat shares line 3; bridge lines sit at 23..20
	assign want = req_i | {8'h0, local_line, 20'h0} |
		{28'h0, temp_hi_i, 3'h0};
	assign pins_o = (want ~^ 32'h0000_0021) | 32'hc000_0012;
endmodule

// *** board_interrupt_routing_bench.sv ***
// self-checking bench for board interrupt routing.
// assumes bir_top, bir_periph and the checker are compiled first.
`timescale 1ns/1ps
module board_interrupt_routing_bench;
import bir_pkg::*;
logic core_clk_i, srst_i, cpu_en, pci_en, temp_hi, nmi;
logic [3:0] bsrc;
logic [7:0] bmap;
logic [31:0] req, pins, pending;
bir_src_t src;
bir_route_t route;
int failures, total_checks;
bir_periph u_bir_periph (.req_i(req), .temp_hi_i(temp_hi),
	.bridge_src_i(bsrc), .bridge_map_i(bmap), .pins_o(pins));
bir_top u_bir_top (.core_clk_i(core_clk_i), .srst_i(srst_i),
	.general_port_input_i(pins), .cpu_int_en_i(cpu_en),
	.pci_int_en_i(pci_en), .pending_o(pending), .src_o(src),
	.route_o(route), .nonmaskable_o(nmi));
task automatic check(input logic [31:0] exp, input logic [31:0] got);
	total_checks++;
	if (got !== exp)
	begin
		failures++;
		$display("[FAIL] %0t exp %h got %h", $time, exp, got);
	end
endtask
task automatic report_and_stop;
	$display("checks %0d failures %0d", total_checks, failures);
	if (failures == 0 && total_checks > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
// three edges of latency, fourth edge samples
task automatic apply(input logic [31:0] r);
	req <= r;
	repeat (4) @(posedge core_clk_i);
endtask
task automatic one_source;
	logic [31:0] e;
	logic [15:0] s;
	for (int i = 0; i < 32; i++)
	begin
		e = (32'h1 << i) & BIR_SRC_MASK;
		s = {e[23:16], e[7:5], e[3:2], e[0], 2'h0};
		apply(32'h1 << i);
		check(e, pending);
		check({16'h0, s}, {16'h0, src});
		check({31'h0, i == 6}, {31'h0, nmi});
	end
endtask
task automatic route_enables;
	for (int k = 0; k < 4; k++)
	begin
		cpu_en <= k[1];
		pci_en <= k[0];
		apply(32'h1);
		check(k & 32'h3, {30'h0, route});
	end
	apply(32'h0);
	check(32'h0, {30'h0, route});
endtask
task automatic hold_level;
	apply(32'h4);
	repeat (20)
	begin
		@(posedge core_clk_i);
		check(32'h4, pending);
	end
	temp_hi <= 1'b1;
	apply(32'h0);
	check(32'h8, pending);
	temp_hi <= 1'b0;
	apply(32'h0);
	check(32'h0, pending);
endtask
// reversed map: bridge source 0 lands on local line 3
task automatic bridge_map;
	bmap <= 8'h1b;
	bsrc <= 4'h1;
	apply(32'h0);
	check(32'h0080_0000, pending);
	check(32'h0000_8000, {16'h0, src});
	bsrc <= 4'h6;
	apply(32'h0);
	check(32'h0060_0000, pending);
	bmap <= 8'he4;
	bsrc <= 4'h0;
	apply(32'h0);
	check(32'h0, pending);
endtask
// reset in mid-run with high-active pins low at release
task automatic reset_midrun;
	apply(32'h21);
	check(32'h21, pending);
	srst_i <= 1'b1;
	repeat (2) @(posedge core_clk_i);
	check(32'h0, pending);
	check(32'h0, {30'h0, route});
	check(32'h0, {31'h0, nmi});
	req <= 32'h0;
	srst_i <= 1'b0;
	repeat (6)
	begin
		@(posedge core_clk_i);
		check(32'h0, pending);
	end
endtask
initial
begin
	core_clk_i = 1'b0;
	forever #10 core_clk_i = ~core_clk_i;
end
initial
begin
	failures = 0;
	total_checks = 0;
	srst_i = 1'b1;
	cpu_en = 1'b1;
	pci_en = 1'b1;
	temp_hi = 1'b0;
	bsrc = 4'h0;
	bmap = 8'he4;
	req = 32'h0;
	repeat (5) @(posedge core_clk_i);
	srst_i <= 1'b0;
	one_source();
	route_enables();
	hold_level();
	bridge_map();
	reset_midrun();
	report_and_stop();
end
endmodule
